/* File: bfps_pkg.sv */
// Shared constants and state type for the boost fault protection sequencer
package bfps_pkg;

  // Time base
  localparam int CLK_MHZ = 100;                 // System clock rate in MHz

  // Qualification and wait times, and switching frequencies, in their own units
  localparam int SC_TIME_NS     = 13000;        // Short-current persistence, ns
  localparam int OUTLOW_TIME_MS = 2;            // Output-low window at start-up, ms
  localparam int RETRY_TIME_MS  = 57;           // Wait before the single retry, ms
  localparam int ENLOW_TIME_MS  = 74;           // Enable-low time before full shutdown, ms
  localparam int FREQ_LO_KHZ    = 600;          // Low switching frequency, kHz
  localparam int FREQ_HI_KHZ    = 1200;         // High switching frequency, kHz

  // Derived cycle counts; least times round up
  localparam int SC_CYC     = (SC_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int OUTLOW_CYC = OUTLOW_TIME_MS * CLK_MHZ * 1000;
  localparam int RETRY_CYC  = RETRY_TIME_MS * CLK_MHZ * 1000;
  localparam int ENLOW_CYC  = ENLOW_TIME_MS * CLK_MHZ * 1000;

  // Switching period lengths in cycles, rounded down
  localparam int PER_W = 8;
  localparam logic [PER_W-1:0] PER_LO_CYC = PER_W'((CLK_MHZ * 1000) / FREQ_LO_KHZ);
  localparam logic [PER_W-1:0] PER_HI_CYC = PER_W'((CLK_MHZ * 1000) / FREQ_HI_KHZ);

  // Timer counter width, wide enough for the longest wait
  localparam int TMR_W = 24;

  // Synchroniser input count; the stage count is fixed at three
  localparam int SYNC_N = 12;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_STARTUP,
    ST_RUN,
    ST_EN_HOLD,
    ST_RETRY,
    ST_LATCHED,
    ST_THERMAL
  } bfps_state_t;

endpackage

/* File: bfps_qual_timer.sv */
// Saturating persistence timer: done once run has held longer than LIMIT cycles
`timescale 1ns/1ps
module bfps_qual_timer
  import bfps_pkg::*;
#(
  parameter int LIMIT = 1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  bfps_tmr_if.tmr   tif
);

  localparam logic [TMR_W-1:0] LIM = TMR_W'(LIMIT);

  logic [TMR_W-1:0] cnt_ff;   // Cycles run has been high
  logic             done_ff;  // Limit passed

  // Count while running, restart whenever run drops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else if (!tif.run)
      cnt_ff <= '0;
    else if (cnt_ff != LIM)
      cnt_ff <= cnt_ff + TMR_W'(1);
  end

  // Done only after the full limit, a strict "longer than"
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      done_ff <= 1'b0;
    else
      done_ff <= tif.run && (cnt_ff == LIM);
  end

  assign tif.done = done_ff;

endmodule

/* File: bfps_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module bfps_sync #(
  parameter int N = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] din,
  output logic      [N-1:0] dout
);

  logic [N-1:0] s1_ff;   // Metastability catcher, read only by s2
  logic [N-1:0] s2_ff;   // Second stage
  logic [N-1:0] s3_ff;   // Third stage
  logic [N-1:0] out_ff;  // Accepted level

  // Shift chain; all zero after reset, so a floating pin reads inactive
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a bit only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      out_ff <= '0;
    else
      out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
  end

  assign dout = out_ff;

endmodule

/* File: bfps_tmr_if.sv */
// Run and done handshake between the sequencer and its qualification timers
`timescale 1ns/1ps
interface bfps_tmr_if;
  logic run;   // Count while high, clear while low
  logic done;  // Limit exceeded, held while run stays high
  modport ctl (output run, input done);
  modport tmr (input run, output done);
endinterface

/* File: bfps_top.sv */
// Protection and enable sequencer for a boost converter
`timescale 1ns/1ps
module bfps_top
  import bfps_pkg::*;
#(
  parameter int OUTLOW_CYCLES = OUTLOW_CYC,
  parameter int RETRY_CYCLES  = RETRY_CYC,
  parameter int ENLOW_CYCLES  = ENLOW_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en_pin,
  input  wire logic freq_sel_pin,
  input  wire logic soft_start_low,
  input  wire logic oc_trip,
  input  wire logic short_current_threshold,
  input  wire logic out_below_in,
  input  wire logic overvoltage_guard,
  input  wire logic overvoltage_clear,
  input  wire logic input_undervoltage_lock,
  input  wire logic over_temp,
  input  wire logic over_temp_clear,
  input  wire logic loop_off_req,
  input  wire logic out_in_regulation,
  output logic      power_sw_on,
  output logic      iso_sw_on,
  output logic      shutdown,
  output logic      latched_fault,
  output logic      sc_fault,
  output logic      out_low_fault,
  output logic      freq_hi
);

  // Synchronised pin levels
  logic [SYNC_N-1:0] pins_raw;     // Raw comparator and pin levels
  logic [SYNC_N-1:0] pins_s;       // After three-stage filter
  logic              en_s;         // Enable level
  logic              fsel_s;       // Frequency select level
  logic              ss_low_s;     // Soft-start held at ground
  logic              oc_s;         // Inductor current at limit
  logic              sc_s;         // Inductor above short-current level
  logic              olow_s;       // Output below input minus margin
  logic              ovp_s;        // Output above overvoltage level
  logic              ovclr_s;      // Output below level minus hysteresis
  logic              input_undervoltage_lock_s;       // Input undervoltage
  logic              ot_s;         // Overtemperature
  logic              otclr_s;      // Temperature fell by the hysteresis
  logic              loff_s;       // Loop asks pulse end

  assign pins_raw = {out_in_regulation, loop_off_req, over_temp_clear, over_temp,
                     input_undervoltage_lock, overvoltage_clear, overvoltage_guard,
                     out_below_in, short_current_threshold, oc_trip, soft_start_low,
                     freq_sel_pin};

  // Enable gets its own chain so its reset value can be the disabled level
  logic en_sync;                   // Filtered enable
  logic reg_s;                     // Output in regulation

  bfps_sync #(.N(SYNC_N)) u_sync (.clk(clk), .rst_n(rst_n), .din(pins_raw), .dout(pins_s));

  // Enable reads low until the pin settles, like the pull-down
  bfps_sync #(.N(1)) u_sync_en (.clk(clk), .rst_n(rst_n), .din(en_pin), .dout(en_sync));

  assign en_s     = en_sync;
  assign fsel_s   = pins_s[0];
  assign ss_low_s = pins_s[1];
  assign oc_s     = pins_s[2];
  assign sc_s     = pins_s[3];
  assign olow_s   = pins_s[4];
  assign ovp_s    = pins_s[5];
  assign ovclr_s  = pins_s[6];
  assign input_undervoltage_lock_s   = pins_s[7];
  assign ot_s     = pins_s[8];
  assign otclr_s  = pins_s[9];
  assign loff_s   = pins_s[10];
  assign reg_s    = pins_s[11];

  // Sequencer state
  bfps_state_t state_ff;           // Current state
  bfps_state_t nxt_state;          // Next state
  logic        retry_used_ff;      // Single retry already spent
  logic        sc_fault_ff;        // Short-current fault seen
  logic        olow_fault_ff;      // Output-low fault seen
  logic        ovp_block_ff;       // Switching held off by overvoltage
  logic        oc_limit_ff;        // Pulse ended by current limit
  logic        pwr_ff;             // Power switch drive
  logic        iso_ff;             // Isolation switch drive
  logic [PER_W-1:0] per_cnt_ff;    // Cycles left in period
  logic        period_start;       // First cycle of a period
  logic        sw_allowed;         // Pulses may be issued
  logic        sc_hit;             // Short-current fault this cycle
  logic        olow_hit;           // Output-low fault this cycle

  // Qualification timers
  bfps_tmr_if sc_t ();
  bfps_tmr_if ol_t ();
  bfps_tmr_if rt_t ();
  bfps_tmr_if el_t ();

  // Short current persistence; a switch node short trips the same path
  assign sc_t.run = sc_s && (state_ff == ST_STARTUP || state_ff == ST_RUN);
  // Window counts only while the output is low in start-up, restarting whenever it recovers
  assign ol_t.run = olow_s && (state_ff == ST_STARTUP);
  assign rt_t.run = (state_ff == ST_RETRY);
  assign el_t.run = (state_ff == ST_EN_HOLD);

  bfps_qual_timer #(.LIMIT(SC_CYC)) u_sc_tmr (.clk(clk), .rst_n(rst_n), .tif(sc_t));

  bfps_qual_timer #(.LIMIT(OUTLOW_CYCLES)) u_ol_tmr (.clk(clk), .rst_n(rst_n), .tif(ol_t));

  bfps_qual_timer #(.LIMIT(RETRY_CYCLES)) u_rt_tmr (.clk(clk), .rst_n(rst_n), .tif(rt_t));

  bfps_qual_timer #(.LIMIT(ENLOW_CYCLES)) u_el_tmr (.clk(clk), .rst_n(rst_n), .tif(el_t));

  assign sc_hit   = sc_t.done;
  assign olow_hit = (state_ff == ST_STARTUP && ol_t.done) || (state_ff == ST_RUN && olow_s);

  // Next state; heat wins, then enable, then faults
  always_comb
  begin
    nxt_state = state_ff;
    if (ot_s && state_ff != ST_THERMAL)
      nxt_state = ST_THERMAL;
    else
    begin
      case (state_ff)
        ST_OFF:
          if (en_s)
            nxt_state = ST_STARTUP;
        ST_STARTUP:
          if (!en_s)
            nxt_state = ST_EN_HOLD;
          else if (sc_hit)
            nxt_state = retry_used_ff ? ST_LATCHED : ST_RETRY;
          else if (olow_hit)
            nxt_state = ST_LATCHED;
          else if (reg_s)
            nxt_state = ST_RUN;
        ST_RUN:
          if (!en_s)
            nxt_state = ST_EN_HOLD;
          else if (olow_hit)
            nxt_state = ST_LATCHED;
          else if (sc_hit)
            nxt_state = retry_used_ff ? ST_LATCHED : ST_RETRY;
        ST_EN_HOLD:
          if (en_s)
            nxt_state = ST_STARTUP;
          else if (el_t.done)
            nxt_state = ST_OFF;
        ST_RETRY:
          if (!en_s)
            nxt_state = ST_OFF;
          else if (rt_t.done)
            nxt_state = ST_STARTUP;
        ST_LATCHED:
          // Only the low half of a toggle, or overtemperature, leaves here
          if (!en_s)
            nxt_state = ST_OFF;
        ST_THERMAL:
          if (otclr_s && !ot_s)
            nxt_state = en_s ? ST_STARTUP : ST_OFF;
        default:
          nxt_state = ST_OFF;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk)
    if (!rst_n)
      state_ff <= ST_OFF;
    else
      state_ff <= nxt_state;

  // Retry bookkeeping; a fresh enable gives back the retry
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      retry_used_ff <= 1'b0;
    else if (nxt_state == ST_RETRY)
      retry_used_ff <= 1'b1;
    else if (nxt_state == ST_STARTUP && (state_ff == ST_OFF || state_ff == ST_EN_HOLD))
      retry_used_ff <= 1'b0;
  end

  // Fault flags; a new fault wins over the toggle clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sc_fault_ff   <= 1'b0;
      olow_fault_ff <= 1'b0;
    end
    else
    begin
      if (sc_hit)
        sc_fault_ff <= 1'b1;
      else if (state_ff == ST_OFF && en_s)
        sc_fault_ff <= 1'b0;
      if (olow_hit && nxt_state == ST_LATCHED)
        olow_fault_ff <= 1'b1;
      else if (state_ff == ST_OFF && en_s)
        olow_fault_ff <= 1'b0;
    end
  end

  // Overvoltage hysteresis; the trip wins over the release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ovp_block_ff <= 1'b0;
    else if (ovp_s)
      ovp_block_ff <= 1'b1;
    else if (ovclr_s)
      ovp_block_ff <= 1'b0;
  end

  // Period counter; frequency follows the select pin at each reload
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      per_cnt_ff <= '0;
    else if (per_cnt_ff == '0)
      per_cnt_ff <= (fsel_s ? PER_HI_CYC : PER_LO_CYC) - PER_W'(1);
    else
      per_cnt_ff <= per_cnt_ff - PER_W'(1);
  end

  assign period_start = (per_cnt_ff == '0);

  // Pulses need an active state, good input, no overvoltage, soft-start released
  assign sw_allowed = (state_ff == ST_STARTUP || state_ff == ST_RUN) && en_s && !ot_s
                      && !input_undervoltage_lock_s && !ovp_block_ff && !ovp_s && !ss_low_s;

  // Current limit latch; cleared only by a new period
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      oc_limit_ff <= 1'b0;
    else if (oc_s)
      oc_limit_ff <= 1'b1;
    else if (period_start)
      oc_limit_ff <= 1'b0;
  end

  // Power switch; cut at once, switched on only at a period start
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pwr_ff <= 1'b0;
    else if (!sw_allowed || oc_s || loff_s || (oc_limit_ff && !period_start))
      pwr_ff <= 1'b0;
    else if (period_start)
      pwr_ff <= 1'b1;
  end

  // Isolation switch; soft-start does not open it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      iso_ff <= 1'b0;
    else
      iso_ff <= !input_undervoltage_lock_s && !ot_s && (nxt_state == ST_STARTUP || nxt_state == ST_RUN
                || nxt_state == ST_EN_HOLD);
  end

  assign power_sw_on   = pwr_ff;
  assign iso_sw_on     = iso_ff;
  assign shutdown      = (state_ff == ST_OFF);
  assign latched_fault = (state_ff == ST_LATCHED);
  assign sc_fault      = sc_fault_ff;
  assign out_low_fault = olow_fault_ff;
  assign freq_hi       = fsel_s;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_en_fall;
    $fell(en_s) && state_ff == ST_RUN && !ot_s;
  endsequence

  sequence s_sc_retry;
    state_ff == ST_RUN && sc_hit && retry_used_ff && en_s && !ot_s;
  endsequence

  chk_oc_cutoff: assert property (oc_s |=> !power_sw_on)
    else $error("power switch on during overcurrent");
  chk_period_restart: assert property ($rose(power_sw_on) |-> $past(period_start))
    else $error("power switch turned on mid-period");
  chk_sc_isolate: assert property (sc_hit && !input_undervoltage_lock_s |=> !iso_sw_on)
    else $error("isolation stayed closed after short current");
  chk_outlow_latch: assert property (state_ff == ST_STARTUP && ol_t.done && en_s && !ot_s && !sc_hit
    |=> state_ff == ST_LATCHED [*2])
    else $error("output-low at start-up not latched");
  chk_retry_start: assert property (state_ff == ST_RETRY && rt_t.done && en_s && !ot_s
    |=> state_ff == ST_STARTUP && retry_used_ff)
    else $error("retry did not start up");
  chk_second_short: assert property (s_sc_retry |=> state_ff == ST_LATCHED && !iso_sw_on)
    else $error("second short fault not latched");
  chk_run_outlow: assert property (state_ff == ST_RUN && olow_s && en_s && !ot_s
    |=> state_ff == ST_LATCHED)
    else $error("output-low after start-up not immediate");
  chk_ovp_stop: assert property (ovp_s |=> !power_sw_on until_with !ovp_block_ff)
    else $error("switching during overvoltage hold");
  chk_input_undervoltage_lock_off: assert property (input_undervoltage_lock_s |=> !power_sw_on && !iso_sw_on)
    else $error("switch on under undervoltage");
  chk_en_low_hold: assert property (s_en_fall |=> !power_sw_on && iso_sw_on == !input_undervoltage_lock_s)
    else $error("enable low did not keep isolation closed");

endmodule

/* File: tb_bfps_top.sv */
// Self-checking bench for the boost fault protection sequencer
`timescale 1ns/1ps
module tb_bfps_top;
  import bfps_pkg::*;
  localparam int OL = 200;   // Shortened output-low window
  localparam int RT = 300;   // Shortened retry wait
  localparam int EL = 400;   // Shortened enable-low hold
  logic clk, rst_n, en_pin, freq_sel_pin, soft_start_low, oc_trip;
  logic short_current_threshold, out_below_in, overvoltage_guard, overvoltage_clear;
  logic input_undervoltage_lock, over_temp, over_temp_clear, loop_off_req, out_in_regulation;
  logic power_sw_on, iso_sw_on, shutdown, latched_fault, sc_fault, out_low_fault, freq_hi;
  int   err_total;           // Mismatches seen
  int   checks_done;         // Comparisons made
  int   cycles;              // Hang guard

  bfps_top #(.OUTLOW_CYCLES(OL), .RETRY_CYCLES(RT), .ENLOW_CYCLES(EL)) dut (
    .clk, .rst_n, .en_pin, .freq_sel_pin, .soft_start_low, .oc_trip,
    .short_current_threshold, .out_below_in, .overvoltage_guard, .overvoltage_clear,
    .input_undervoltage_lock, .over_temp, .over_temp_clear, .loop_off_req,
    .out_in_regulation, .power_sw_on, .iso_sw_on, .shutdown, .latched_fault,
    .sc_fault, .out_low_fault, .freq_hi);

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Wait n edges, then step off the edge so drives never race sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait for the power drive; one period is 166 cycles at most
  task automatic wait_pw(input logic v);
    int k;
    k = 0;
    while (power_sw_on !== v && k < 200)
    begin
      cyc(1);
      k++;
    end
  endtask

  // Cycles between two pulse starts; each pulse is ended early by the loop
  task automatic period_len(output int n);
    loop_off_req = 1'b1;
    cyc(6);
    loop_off_req = 1'b0;
    wait_pw(1'b1);
    loop_off_req = 1'b1;
    cyc(6);
    loop_off_req = 1'b0;
    n = 6;
    while (power_sw_on !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
  endtask

  // Enable low then high, clearing any latch; short-current, output-low and current-limit inputs released first
  task automatic toggle();
    {short_current_threshold, out_below_in, oc_trip, loop_off_req, out_in_regulation} = '0;
    en_pin = 1'b0;
    cyc(8);
    en_pin = 1'b1;
    cyc(8);
  endtask

  task automatic t_reset();
    chk(shutdown, 1'b1);
    chk(iso_sw_on, 1'b0);
    chk(power_sw_on, 1'b0);
    $display("reset test done");
  endtask

  task automatic t_pwm();
    int n;                    // Measured period in cycles
    toggle();
    chk(iso_sw_on, 1'b1);
    chk(freq_hi, 1'b0);
    period_len(n);
    chk(n, 32'(PER_LO_CYC));
    wait_pw(1'b1);
    oc_trip = 1'b1;
    cyc(6);
    chk(power_sw_on, 1'b0);
    oc_trip = 1'b0;
    wait_pw(1'b1);
    chk(power_sw_on, 1'b1);
    loop_off_req = 1'b1;
    cyc(6);
    chk(power_sw_on, 1'b0);
    loop_off_req = 1'b0;
    freq_sel_pin = 1'b1;
    cyc(6);
    chk(freq_hi, 1'b1);
    period_len(n);
    chk(n, 32'(PER_HI_CYC));
    $display("pwm test done");
  endtask

  task automatic t_ss_ovp();
    toggle();
    soft_start_low = 1'b1;
    cyc(180);
    chk(power_sw_on, 1'b0);
    chk(iso_sw_on, 1'b1);
    soft_start_low = 1'b0;
    wait_pw(1'b1);
    overvoltage_guard = 1'b1;
    cyc(6);
    chk(power_sw_on, 1'b0);
    overvoltage_guard = 1'b0;
    cyc(200);
    chk(power_sw_on, 1'b0);
    overvoltage_clear = 1'b1;
    wait_pw(1'b1);
    chk(power_sw_on, 1'b1);
    overvoltage_clear = 1'b0;
    $display("soft-start and overvoltage test done");
  endtask

  task automatic t_short();
    toggle();
    short_current_threshold = 1'b1;
    cyc(1290);
    chk(iso_sw_on, 1'b1);
    cyc(20);
    chk(sc_fault, 1'b1);
    chk(iso_sw_on, 1'b0);
    short_current_threshold = 1'b0;
    cyc(RT - 20);
    chk(iso_sw_on, 1'b0);
    cyc(40);
    chk(iso_sw_on, 1'b1);
    out_in_regulation = 1'b1;
    cyc(6);
    short_current_threshold = 1'b1;
    cyc(1320);
    chk(latched_fault, 1'b1);
    toggle();
    chk(latched_fault, 1'b0);
    chk(sc_fault, 1'b0);
    // Short that never clears: the retry must fail into the latch
    short_current_threshold = 1'b1;
    cyc(RT + 2660);
    chk(latched_fault, 1'b1);
    chk(iso_sw_on, 1'b0);
    $display("short-current test done");
  endtask

  task automatic t_outlow();
    toggle();
    en_pin = 1'b0;
    cyc(8);
    out_below_in = 1'b1;
    en_pin = 1'b1;
    cyc(OL - 10);
    chk(latched_fault, 1'b0);
    cyc(30);
    chk(latched_fault, 1'b1);
    chk(out_low_fault, 1'b1);
    cyc(500);
    chk(iso_sw_on, 1'b0);
    chk(latched_fault, 1'b1);
    // After start-up the same condition latches at once
    toggle();
    out_in_regulation = 1'b1;
    cyc(6);
    out_below_in = 1'b1;
    cyc(8);
    chk(latched_fault, 1'b1);
    // Power-on reset clears the latch as a toggle would
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    chk(latched_fault, 1'b0);
    chk(out_low_fault, 1'b0);
    chk(shutdown, 1'b1);
    $display("output-low test done");
  endtask

  task automatic t_enable();
    toggle();
    out_in_regulation = 1'b1;
    cyc(8);
    wait_pw(1'b1);
    en_pin = 1'b0;
    cyc(6);
    chk(power_sw_on, 1'b0);
    chk(iso_sw_on, 1'b1);
    cyc(EL - 20);
    chk(iso_sw_on, 1'b1);
    cyc(40);
    chk(iso_sw_on, 1'b0);
    chk(shutdown, 1'b1);
    $display("enable test done");
  endtask

  task automatic t_uv_thermal();
    toggle();
    out_in_regulation = 1'b1;
    input_undervoltage_lock = 1'b1;
    cyc(8);
    chk(power_sw_on, 1'b0);
    chk(iso_sw_on, 1'b0);
    input_undervoltage_lock = 1'b0;
    cyc(8);
    chk(iso_sw_on, 1'b1);
    over_temp = 1'b1;
    cyc(8);
    chk(power_sw_on, 1'b0);
    chk(iso_sw_on, 1'b0);
    over_temp = 1'b0;
    cyc(20);
    chk(iso_sw_on, 1'b0);
    over_temp_clear = 1'b1;
    cyc(10);
    chk(iso_sw_on, 1'b1);
    over_temp_clear = 1'b0;
    $display("undervoltage and thermal test done");
  endtask

  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard; all tests need well under this many cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  // Main sequence
  initial
  begin
    {clk, rst_n, en_pin, freq_sel_pin, soft_start_low, oc_trip} = '0;
    {short_current_threshold, out_below_in, overvoltage_guard, overvoltage_clear} = '0;
    {input_undervoltage_lock, over_temp, over_temp_clear, loop_off_req, out_in_regulation} = '0;
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    t_reset();
    t_pwm();
    t_ss_ovp();
    t_short();
    t_outlow();
    t_enable();
    t_uv_thermal();
    complete_run();
  end
endmodule
